/* File: dmc_defines.vh */
// How it works
// - After power-up wait 200 us, then run 8 row-strobe cycles before any access.
// - Refresh all 512 rows every 8 ms, one refresh cycle per row.
// - Column-before-row refresh: column strobe low 10 ns before, 30 ns after row fall.
// - In reads keep write enable high until column or row strobe rises.
// - Space random cycle starts at least 190 ns (fast) or 220 ns (slow).
// - Row strobe low at most 10,000 ns, or 100,000 ns in fast page mode.
// - Page mode column cycles at least 60 ns (fast) or 70 ns (slow) apart.
// - Page mode column strobe high at least 10 ns (fast) or 15 ns (slow).
// - Write enable low at least 25 ns (fast) or 30 ns (slow) before row rises.
// - Factory test pin is held low for normal operation.
`ifndef DMC_DEFINES_VH
`define DMC_DEFINES_VH
`define DMC_CLK_PERIOD_NS   5
`define DMC_POWERUP_US      200
`define DMC_WAKE_CYCLES     8
`define DMC_REFRESH_MS      8
`define DMC_REFRESH_ROWS    512
`define DMC_ROW_PRE_NS      90
`define DMC_ROW_LOW_NS      120
`define DMC_CYCLE_NS        220
`define DMC_RCD_NS          30
`define DMC_COL_LOW_NS      30
`define DMC_CBR_SETUP_NS    10
`define DMC_CBR_HOLD_NS     30
`define DMC_ACCESS_NS       120
`define DMC_ADDR_W          10
`define DMC_ADDR_BITS       20
`define DMC_DATA_W          8
`endif

/* File: dmc_tick.v */
`timescale 1ns/1ps
`default_nettype none
`include "dmc_defines.vh"
module dmc_tick #(
    parameter W    = 16,
    parameter PERIOD = 16'h0640
) (
    input  wire         clk_sys_i,
    input  wire         reset_i,
    input  wire         ce_i,
    input  wire         ack_i,
    output reg          due_o
);
    reg [W-1:0] count;

    // Raises a sticky request every PERIOD cycles; the set wins over an ack.
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            count <= {W{1'b0}};
            due_o <= 1'b0;
        end else if (ce_i) begin
            if (count == PERIOD[W-1:0] - 1'b1) begin
                count <= {W{1'b0}};
                due_o <= 1'b1;
            end else begin
                count <= count + 1'b1;
                if (ack_i) begin
                    due_o <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: dmc_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "dmc_defines.vh"
module dmc_ctrl #(
    parameter POWERUP_CYC = 40000,
    parameter REF_INTERVAL = 3125
) (
    input  wire                        clk_sys_i,
    input  wire                        reset_i,
    input  wire                        ce_i,
    input  wire                        req_valid_i,
    input  wire                        req_write_i,
    input  wire [`DMC_ADDR_BITS-1:0]   req_addr_i,
    input  wire [`DMC_DATA_W-1:0]      req_wdata_i,
    input  wire                        req_wparity_i,
    output wire                        req_ready_o,
    output reg                         rsp_valid_o,
    output reg  [`DMC_DATA_W-1:0]      rsp_rdata_o,
    output reg                         rsp_rparity_o,
    output reg                         init_done_o,
    output reg                         row_strobe_n_o,
    output reg                         column_strobe_n_o,
    output reg                         parity_column_strobe_n_o,
    output reg                         write_enable_n_o,
    output reg  [`DMC_ADDR_W-1:0]      muxed_address_o,
    output reg  [`DMC_DATA_W-1:0]      data_lanes_o,
    output reg                         data_lanes_oe_o,
    input  wire [`DMC_DATA_W-1:0]      data_lanes_i,
    output reg                         parity_data_in_o,
    input  wire                        parity_data_out_i,
    output wire                        test_pin_o
);
    // ----------------------------------------------------------------
    // Timing counts
    // ----------------------------------------------------------------
    localparam P = `DMC_CLK_PERIOD_NS;
    localparam [7:0] C_PRE  = (`DMC_ROW_PRE_NS + P - 1) / P;
    localparam [7:0] C_RCD  = (`DMC_RCD_NS + P - 1) / P;
    localparam [7:0] C_CAS  = (`DMC_COL_LOW_NS + `DMC_ACCESS_NS + P - 1) / P;
    localparam [7:0] C_RAS  = (`DMC_ROW_LOW_NS + P - 1) / P;
    localparam [7:0] C_CSR  = (`DMC_CBR_SETUP_NS + P - 1) / P;
    localparam [7:0] C_CHR  = (`DMC_CBR_HOLD_NS + P - 1) / P;
    localparam [7:0] C_CYC  = (`DMC_CYCLE_NS + P - 1) / P;
    localparam [7:0] C_TAIL = C_CYC - C_RAS;

    localparam [6:0] S_PWR  = 7'h01;
    localparam [6:0] S_IDLE = 7'h02;
    localparam [6:0] S_ROW  = 7'h04;
    localparam [6:0] S_COL  = 7'h08;
    localparam [6:0] S_CBR  = 7'h10;
    localparam [6:0] S_HIGH = 7'h20;
    localparam [6:0] S_PRE  = 7'h40;

    reg [6:0]  state;
    reg [17:0] wait_cnt;
    reg [7:0]  cyc_cnt;
    reg [3:0]  wake_cnt;
    reg        is_wr;
    reg        ref_ack;
    wire       ref_due;
    reg  [`DMC_ADDR_W-1:0] col_hold;
    wire [`DMC_DATA_W:0]   rd_pins;
    wire [`DMC_DATA_W:0]   rd_clean;

    // ----------------------------------------------------------------
    // Refresh pacing
    // ----------------------------------------------------------------
    dmc_tick #(
        .W      (16),
        .PERIOD (REF_INTERVAL[15:0])
    ) u_tick (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .ack_i     (ref_ack),
        .due_o     (ref_due)
    );

    assign test_pin_o  = 1'b0;
    assign req_ready_o = (state == S_IDLE) && init_done_o && !ref_due;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state                    <= S_PWR;
            wait_cnt                 <= 18'h0_0000;
            cyc_cnt                  <= 8'h00;
            wake_cnt                 <= 4'h0;
            is_wr                    <= 1'b0;
            ref_ack                  <= 1'b0;
            init_done_o              <= 1'b0;
            rsp_valid_o              <= 1'b0;
            rsp_rdata_o              <= 8'h00;
            rsp_rparity_o            <= 1'b0;
            row_strobe_n_o           <= 1'b1;
            column_strobe_n_o        <= 1'b1;
            parity_column_strobe_n_o <= 1'b1;
            write_enable_n_o         <= 1'b1;
            muxed_address_o          <= 10'h000;
            data_lanes_o             <= 8'h00;
            data_lanes_oe_o          <= 1'b0;
            parity_data_in_o         <= 1'b0;
        end else if (ce_i) begin
            rsp_valid_o <= 1'b0;
            ref_ack     <= 1'b0;
            cyc_cnt     <= cyc_cnt + 8'h01;
            case (state)
                S_PWR: begin
                    if (wait_cnt == POWERUP_CYC[17:0]) begin
                        state   <= S_PRE;
                        cyc_cnt <= 8'h00;
                    end else begin
                        wait_cnt <= wait_cnt + 18'h0_0001;
                    end
                end
                S_IDLE: begin
                    cyc_cnt <= 8'h00;
                    if (ref_due) begin
                        ref_ack                  <= 1'b1;
                        column_strobe_n_o        <= 1'b0;
                        parity_column_strobe_n_o <= 1'b0;
                        state                    <= S_CBR;
                    end else if (req_valid_i && init_done_o) begin
                        is_wr            <= req_write_i;
                        muxed_address_o  <= req_addr_i[19:10];
                        data_lanes_o     <= req_wdata_i;
                        parity_data_in_o <= req_wparity_i;
                        data_lanes_oe_o  <= req_write_i;
                        write_enable_n_o <= !req_write_i;
                        row_strobe_n_o   <= 1'b0;
                        state            <= S_ROW;
                    end
                end
                S_CBR: begin
                    if (cyc_cnt == C_CSR) begin
                        row_strobe_n_o <= 1'b0;
                    end
                    if (cyc_cnt == C_CSR + C_CHR) begin
                        column_strobe_n_o        <= 1'b1;
                        parity_column_strobe_n_o <= 1'b1;
                    end
                    if (cyc_cnt == C_CSR + C_RAS) begin
                        row_strobe_n_o <= 1'b1;
                        state          <= S_PRE;
                        cyc_cnt        <= 8'h00;
                    end
                end
                S_ROW: begin
                    if (cyc_cnt == C_RCD - 8'h01) begin
                        muxed_address_o          <= col_hold;
                        column_strobe_n_o        <= 1'b0;
                        parity_column_strobe_n_o <= 1'b0;
                        state                    <= S_COL;
                    end
                end
                S_COL: begin
                    if (cyc_cnt == C_CAS) begin
                        rsp_rdata_o   <= rd_clean[`DMC_DATA_W-1:0];
                        rsp_rparity_o <= rd_clean[`DMC_DATA_W];
                        rsp_valid_o   <= !is_wr;
                        row_strobe_n_o <= 1'b1;
                        cyc_cnt       <= 8'h00;
                        state         <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    column_strobe_n_o        <= 1'b1;
                    parity_column_strobe_n_o <= 1'b1;
                    write_enable_n_o         <= 1'b1;
                    data_lanes_oe_o          <= 1'b0;
                    state                    <= S_PRE;
                end
                S_PRE: begin
                    if (cyc_cnt >= C_PRE && cyc_cnt >= C_TAIL) begin
                        cyc_cnt <= 8'h00;
                        if (!init_done_o) begin
                            if (wake_cnt == `DMC_WAKE_CYCLES) begin
                                init_done_o <= 1'b1;
                                state       <= S_IDLE;
                            end else begin
                                wake_cnt       <= wake_cnt + 4'h1;
                                row_strobe_n_o <= 1'b0;
                                state          <= S_CBR;
                            end
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Column address hold
    // ----------------------------------------------------------------
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            col_hold <= 10'h000;
        end else if (ce_i && req_ready_o && req_valid_i) begin
            col_hold <= req_addr_i[9:0];
        end
    end

    // ----------------------------------------------------------------
    // Read pin synchronisers
    // ----------------------------------------------------------------
    assign rd_pins = {parity_data_out_i, data_lanes_i};

    genvar gi;
    generate
        for (gi = 0; gi <= `DMC_DATA_W; gi = gi + 1) begin : g_sync
            reg stage_a;
            reg stage_b;
            reg stage_c;
            reg settled;
            // A pin change is taken only once the last two stages agree.
            always @(posedge clk_sys_i or posedge reset_i) begin
                if (reset_i) begin
                    stage_a <= 1'b0;
                    stage_b <= 1'b0;
                    stage_c <= 1'b0;
                    settled <= 1'b0;
                end else if (ce_i) begin
                    stage_a <= rd_pins[gi];
                    stage_b <= stage_a;
                    stage_c <= stage_b;
                    if (stage_b == stage_c) begin
                        settled <= stage_c;
                    end
                end
            end
            assign rd_clean[gi] = settled;
        end
    endgenerate
endmodule
`default_nettype wire

/* File: dmc_chk_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module dmc_chk (
    input wire logic       clk_sys_i,
    input wire logic       reset_i,
    input wire logic       row_strobe_n_o,
    input wire logic       column_strobe_n_o,
    input wire logic       parity_column_strobe_n_o,
    input wire logic       write_enable_n_o,
    input wire logic       data_lanes_oe_o,
    input wire logic       init_done_o,
    input wire logic       test_pin_o
);
    // --------
    // Cycle counters and properties.
    // --------
    int gap;
    int low;
    int falls;
    logic row_q;
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            gap <= 100;
            low <= 0;
            falls <= 0;
            row_q <= 1'b1;
        end else begin
            row_q <= row_strobe_n_o;
            gap <= (row_q && !row_strobe_n_o) ? 1 : gap + 1;
            low <= row_strobe_n_o ? 0 : low + 1;
            falls <= falls + ((row_q && !row_strobe_n_o) ? 1 : 0);
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    sequence s_cbr_hold;
        !column_strobe_n_o [*6];
    endsequence
    AST_TEST_LOW: assert property (test_pin_o == 1'b0)
        else $error("test pin high");
    AST_CYCLE: assert property ($fell(row_strobe_n_o) |-> gap >= 44)
        else $error("row cycles too close");
    AST_ROW_MAX: assert property (low < 2000)
        else $error("row strobe low too long");
    AST_CBR: assert property ($fell(row_strobe_n_o) && !column_strobe_n_o |->
        $past(!column_strobe_n_o, 2) ##0 s_cbr_hold) else $error("refresh strobe timing");
    AST_EARLY: assert property ($fell(column_strobe_n_o) && data_lanes_oe_o |->
        !write_enable_n_o) else $error("write enable late");
    AST_READ_WE: assert property (!column_strobe_n_o && $past(!column_strobe_n_o) &&
        $past(write_enable_n_o) |-> write_enable_n_o) else $error("write enable fell in read");
    AST_COL_RISE: assert property ($fell(column_strobe_n_o) && write_enable_n_o |->
        ##[1:60] column_strobe_n_o) else $error("column strobe held too long in read");
    AST_WE_LEAD: assert property ($rose(row_strobe_n_o) && !$past(write_enable_n_o) |->
        $past(!write_enable_n_o, 6)) else $error("write enable lead short");
    AST_COL_DELAY: assert property ($fell(row_strobe_n_o) && column_strobe_n_o && init_done_o |->
        ##[5:18] $fell(column_strobe_n_o)) else $error("column delay out of range");
    AST_PARITY: assert property ($fell(column_strobe_n_o) |->
        $fell(parity_column_strobe_n_o)) else $error("parity strobe apart");
    AST_WAKE: assert property ($rose(init_done_o) |-> falls >= 8)
        else $error("too few wake cycles");
endmodule
bind dmc_ctrl dmc_chk i_chk (.clk_sys_i, .reset_i, .row_strobe_n_o, .column_strobe_n_o,
    .parity_column_strobe_n_o, .write_enable_n_o, .data_lanes_oe_o, .init_done_o, .test_pin_o);
`default_nettype wire

/* File: dmc_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dmc_mem_model (
    input  wire logic       row_strobe_n_i,
    input  wire logic       column_strobe_n_i,
    input  wire logic       parity_column_strobe_n_i,
    input  wire logic       write_enable_n_i,
    input  wire logic [9:0] muxed_address_i,
    input  wire logic [7:0] data_lanes_i,
    input  wire logic       parity_data_in_i,
    output logic      [7:0] data_lanes_o,
    output logic            parity_data_out_o,
    output int              refresh_count_o
);
    // --------
    // Memory array with muxed address and released outputs inverted.
    // --------
    logic [7:0] mem [0:1048575];
    logic       par [0:1048575];
    logic [9:0] row;
    logic       cbr = 1'b0;
    initial begin
        data_lanes_o = 8'h5A;
        parity_data_out_o = 1'b0;
        refresh_count_o = 0;
    end
    always @(negedge row_strobe_n_i) #1 begin
        cbr = !column_strobe_n_i;
        if (cbr)
            refresh_count_o++;
        else
            row = muxed_address_i;
    end
    always @(negedge column_strobe_n_i) #1 begin
        if (!row_strobe_n_i && !cbr && !write_enable_n_i)
            mem[{row, muxed_address_i}] = data_lanes_i;
        else if (!row_strobe_n_i && !cbr)
            data_lanes_o <= #29 mem[{row, muxed_address_i}];
    end
    always @(negedge parity_column_strobe_n_i) #1 begin
        if (!row_strobe_n_i && !cbr && !write_enable_n_i)
            par[{row, muxed_address_i}] = parity_data_in_i;
        else if (!row_strobe_n_i && !cbr)
            parity_data_out_o <= #29 par[{row, muxed_address_i}];
    end
    always @(posedge column_strobe_n_i)
        data_lanes_o = ~data_lanes_o;
    always @(posedge parity_column_strobe_n_i)
        parity_data_out_o = ~parity_data_out_o;
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0;
    logic [19:0] req_addr_i = 20'h0_0000;
    logic [7:0]  req_wdata_i = 8'h00, rsp_rdata_o, data_lanes_o, data_lanes_i;
    logic [9:0]  muxed_address_o;
    logic req_wparity_i = 1'b0, req_ready_o, rsp_valid_o, rsp_rparity_o, init_done_o;
    logic row_strobe_n_o, column_strobe_n_o, parity_column_strobe_n_o, write_enable_n_o;
    logic data_lanes_oe_o, parity_data_in_o, parity_data_out_i, test_pin_o;
    int miscompares = 0, compares = 0, falls = 0, refs, ref0, i;
    logic [29:0] rows [8];
    // --------
    // Clock, device model and helpers.
    // --------
    always #2.5 clk_sys_i = ~clk_sys_i;
    always @(negedge row_strobe_n_o) falls++;
    dmc_ctrl #(.POWERUP_CYC(50), .REF_INTERVAL(200)) i_dut (.clk_sys_i, .reset_i, .ce_i,
        .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i, .req_wparity_i, .req_ready_o,
        .rsp_valid_o, .rsp_rdata_o, .rsp_rparity_o, .init_done_o, .row_strobe_n_o,
        .column_strobe_n_o, .parity_column_strobe_n_o, .write_enable_n_o, .muxed_address_o,
        .data_lanes_o, .data_lanes_oe_o, .data_lanes_i, .parity_data_in_o, .parity_data_out_i,
        .test_pin_o);
    dmc_mem_model i_mem (.row_strobe_n_i(row_strobe_n_o), .column_strobe_n_i(column_strobe_n_o),
        .parity_column_strobe_n_i(parity_column_strobe_n_o), .write_enable_n_i(write_enable_n_o),
        .muxed_address_i(muxed_address_o), .data_lanes_i(data_lanes_o),
        .parity_data_in_i(parity_data_in_o), .data_lanes_o(data_lanes_i),
        .parity_data_out_o(parity_data_out_i), .refresh_count_o(refs));
    task conclude;
        $display("miscompares=%0d compares=%0d", miscompares, compares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task timeout;
        miscompares++;
        $display("ERROR %0t: wait ran out", $time);
        conclude();
    endtask
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: data %h expected %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task wait_init;
        int n;
        for (n = 0; n < 1000 && init_done_o !== 1'b1; n++) @(negedge clk_sys_i);
        if (n >= 1000) timeout();
    endtask
    // Row layout is write, address, data, parity; reads expect the data and parity given.
    task op(input logic [29:0] r);
        int n;
        @(negedge clk_sys_i);
        {req_write_i, req_addr_i, req_wdata_i, req_wparity_i} = r;
        req_valid_i = 1'b1;
        for (n = 0; n < 1000 && req_ready_o !== 1'b1; n++) @(negedge clk_sys_i);
        if (n >= 1000) timeout();
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        if (!r[29]) begin
            for (n = 0; n < 100 && rsp_valid_o !== 1'b1; n++) @(negedge clk_sys_i);
            if (n >= 100) timeout();
            chk8(rsp_rdata_o, r[8:1]);
            chk1(rsp_rparity_o, r[0]);
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        timeout();
    end
    initial begin
        rows = '{{1'b1, 20'h0_0000, 8'hA5, 1'b1}, {1'b1, 20'hF_FFFF, 8'h3C, 1'b0},
                 {1'b0, 20'h0_0000, 8'hA5, 1'b1}, {1'b0, 20'hF_FFFF, 8'h3C, 1'b0},
                 {1'b1, 20'h0_03FF, 8'h00, 1'b1}, {1'b1, 20'hF_FC00, 8'hFF, 1'b0},
                 {1'b0, 20'h0_03FF, 8'h00, 1'b1}, {1'b0, 20'hF_FC00, 8'hFF, 1'b0}};
        repeat (5) @(negedge clk_sys_i);
        reset_i = 1'b0;
        chk1(init_done_o, 1'b0);
        wait_init();
        chk1(falls >= 8, 1'b1);
        for (i = 0; i < 8; i++) op(rows[i]);
        ref0 = refs;
        repeat (450) @(negedge clk_sys_i);
        chk1(refs > ref0, 1'b1);
        op(rows[2]);
        fork
            op(rows[3]);
            begin
                repeat (10) @(negedge clk_sys_i);
                ce_i = 1'b0;
                repeat (20) @(negedge clk_sys_i);
                ce_i = 1'b1;
            end
        join
        op({1'b1, 20'h1_2345, 8'h77, 1'b1});
        repeat (10) @(negedge clk_sys_i);
        reset_i = 1'b1;
        falls = 0;
        @(negedge clk_sys_i);
        chk1(row_strobe_n_o & column_strobe_n_o & ~data_lanes_oe_o, 1'b1);
        chk1(req_ready_o | init_done_o, 1'b0);
        reset_i = 1'b0;
        wait_init();
        chk1(falls >= 8, 1'b1);
        op({1'b1, 20'h5_4321, 8'h96, 1'b0});
        op({1'b0, 20'h5_4321, 8'h96, 1'b0});
        conclude();
    end
endmodule
`default_nettype wire
